// [verilog/adc_pwr_params.svh]
// Constants shared by both ends of the converter serial link.
// Assumes the includer sees it once per compilation unit.
`ifndef ADC_PWR_PARAMS_SVH
`define ADC_PWR_PARAMS_SVH

// --------------------------------------------------------------
// Control word layout
// --------------------------------------------------------------
`define CTRL_BITS 8
`define CTRL_PM_LO 0
`define CTRL_PM_HI 1
`define CTRL_REF_DIS 5
`define CTRL_RESET 8'h00

// --------------------------------------------------------------
// Frame layout, in serial clock edges
// --------------------------------------------------------------
`define FRAME_EDGES 16
`define SAMPLE_EDGE 2
`define LEAD_ZEROS 4

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define PWRUP_FULL_NS 5000
`define PWRUP_SHORT_NS 1000
`define PWRUP_FULL_CYC ((`PWRUP_FULL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRUP_SHORT_CYC ((`PWRUP_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC 5
`define CS_HIGH_CYC 5

`endif

// [verilog/adc_pwr_pkg.sv]
// Types shared by both ends of the converter serial link.
// Assumes adc_pwr_params.svh is compiled alongside.
`default_nettype none

package adc_pwr_pkg;

  // ------------------------------------------------------------
  // Power-mode field encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    select_controlled_shutdown_mode = 2'b00,
    always_on_mode = 2'b01,
    auto_shutdown_mode = 2'b10,
    auto_standby_mode = 2'b11
  } power_mode_t;

  // ------------------------------------------------------------
  // Sequencer and host states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_WAKING = 2'b10,
    PWR_ON = 2'b11
  } pwr_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SELECT = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_END = 3'b100
  } host_state_t;

endpackage

`default_nettype wire

// [verilog/adc_link_if.sv]
// Serial link between the converter and its host.
// Assumes the bench resolves the data-out wire from dout_oe.
`timescale 1ns/100ps
`default_nettype none

interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;

  modport device (input sclk, input cs_n, input din, output dout, output dout_oe);
  modport host (output sclk, output cs_n, output din, input dout);
endinterface

`default_nettype wire

// [verilog/adc_pwr_device.sv]
// Converter end: serial frame logic on the link clock and the power
// sequencer on the system clock.
// Assumes the host gives all sixteen edges per frame, holds chip-select
// low for three system clocks after the last edge so the end event is
// seen before the frame closes, and high for three between frames.
`timescale 1ns/100ps
`default_nettype none
`include "adc_pwr_params.svh"

// Operation
// - Power-mode field picks one of four behaviours
// - Auto modes power down at 16th rise
// - Auto modes wake at first falling edge
// - Mode zero default, follows chip-select
// - Chip-select rise aborts conversion, powers down
// - Cold start in mode zero
// - Host waits full delay before sampling
// - Standby or external reference: short delay
// - Standby wake gives valid result same frame
// - Read-only host holds data input low
// - Sample on second rising edge
// - Host workaround: dummy frame in mode one
// - Mode one always powered
// - First eight bits load control word
// - Host resends mode every frame
// - Sixteen clocks per frame
// - New frame right after chip-select rise; the device needs chip-select high for three system clocks
// - Mode two auto shutdown, reference off
// - Mode three auto standby, reference on
// - Bit five disables internal reference
// - 1.5 cycles acquire, 14.5 convert
module adc_pwr_device
  import adc_pwr_pkg::*;
#(
  parameter int FULL_CYC = `PWRUP_FULL_CYC,
  parameter int SHORT_CYC = `PWRUP_SHORT_CYC
) (
  adc_link_if.device lnk,
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] conv_data_i,
  output logic [7:0] ctrl_o,
  output logic [1:0] power_mode_o,
  output logic powered_o,
  output logic waking_o,
  output logic ref_on_o,
  output logic result_valid_o,
  output logic conv_abort_o
);

  localparam logic [4:0] LAST_IDX = 5'(`FRAME_EDGES - 1);
  localparam logic [4:0] SAMPLE_IDX = 5'(`SAMPLE_EDGE - 1);
  localparam logic [4:0] CTRL_IDX = 5'(`CTRL_BITS - 1);
  localparam logic [4:0] FRAME_END = 5'(`FRAME_EDGES);

  // ------------------------------------------------------------
  // Link domain: frame counter and control shift
  // ------------------------------------------------------------
  logic [4:0] edge_cnt_ff;
  logic [7:0] shift_ff;
  logic [11:0] sample_ff;
  logic got_ctrl_ff;
  logic got_end_ff;
  logic got_sample_ff;
  logic fall_seen_ff;
  logic dout_ff;
  logic [15:0] out_word;

  // Chip-select high clears the frame; the link clock may stop then
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      edge_cnt_ff <= 5'h00;
    end else if (edge_cnt_ff != FRAME_END) begin
      edge_cnt_ff <= edge_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      shift_ff <= 8'h00;
    end else if (edge_cnt_ff <= CTRL_IDX) begin
      shift_ff <= {shift_ff[6:0], lnk.din};
    end
  end

  // Frame events are levels, raised once and cleared by chip-select
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      got_ctrl_ff <= 1'b0;
      got_end_ff <= 1'b0;
      got_sample_ff <= 1'b0;
      sample_ff <= 12'h000;
    end else begin
      if (edge_cnt_ff == CTRL_IDX) begin
        got_ctrl_ff <= 1'b1;
      end
      if (edge_cnt_ff == LAST_IDX) begin
        got_end_ff <= 1'b1;
      end
      if (edge_cnt_ff == SAMPLE_IDX) begin
        got_sample_ff <= 1'b1;
        sample_ff <= conv_data_i;
      end
    end
  end

  // Leading zeros then result, MSB first, launched on falling edges
  assign out_word = {4'h0, sample_ff};

  always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      fall_seen_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      fall_seen_ff <= 1'b1;
      if (edge_cnt_ff < FRAME_END) begin
        dout_ff <= out_word[4'hF - edge_cnt_ff[3:0]];
      end
    end
  end

  assign lnk.dout = dout_ff;
  assign lnk.dout_oe = fall_seen_ff;

  // ------------------------------------------------------------
  // Crossing into the system clock
  // ------------------------------------------------------------
  // Bits: 4 cs_n, 3 first fall, 2 sample, 1 control word, 0 end
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] sync3_ff;
  logic [4:0] rise;
  logic cs_rise;
  logic cs_fall;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 5'h10;
      sync2_ff <= 5'h10;
      sync3_ff <= 5'h10;
    end else begin
      sync1_ff <= {lnk.cs_n, fall_seen_ff, got_sample_ff, got_ctrl_ff, got_end_ff};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~sync3_ff;
  assign cs_rise = rise[4];
  assign cs_fall = sync3_ff[4] & ~sync2_ff[4];

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [7:0] ctrl_ff;
  power_mode_t mode;
  logic ref_dis;

  // cold start value; kept across power states
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `CTRL_RESET;
    // load; the shift word stays still until chip-select rises
    end else if (rise[1]) begin
      ctrl_ff <= shift_ff;
    end
  end

  assign mode = power_mode_t'(ctrl_ff[`CTRL_PM_HI:`CTRL_PM_LO]);
  assign ref_dis = ctrl_ff[`CTRL_REF_DIS];
  assign ctrl_o = ctrl_ff;
  assign power_mode_o = ctrl_ff[`CTRL_PM_HI:`CTRL_PM_LO];

  // ------------------------------------------------------------
  // Power sequencer
  // ------------------------------------------------------------
  pwr_state_t state_ff;
  pwr_state_t nxt_state;
  logic nxt_load;
  logic nxt_short;
  logic [15:0] delay_ff;
  logic asleep;

  assign asleep = (state_ff == PWR_OFF) || (state_ff == PWR_STANDBY);

  always_comb begin
    nxt_state = state_ff;
    nxt_load = 1'b0;
    nxt_short = 1'b0;
    unique case (mode)
      always_on_mode: begin
        if (asleep) begin
          nxt_state = PWR_WAKING;
          nxt_load = 1'b1;
          nxt_short = ref_dis || (state_ff == PWR_STANDBY);
        end
      end
      select_controlled_shutdown_mode: begin
        if (cs_rise) begin
          nxt_state = PWR_OFF;
        end else if (cs_fall) begin
          nxt_state = PWR_WAKING;
          nxt_load = 1'b1;
          nxt_short = ref_dis;
        end
      end
      auto_shutdown_mode, auto_standby_mode: begin
        if (rise[0]) begin
          nxt_state = (mode == auto_standby_mode) ? PWR_STANDBY : PWR_OFF;
        end else if (rise[3] && asleep) begin
          nxt_state = PWR_WAKING;
          nxt_load = 1'b1;
          nxt_short = ref_dis || (state_ff == PWR_STANDBY);
        end
      end
    endcase
    if ((nxt_state == PWR_WAKING) && !nxt_load && (delay_ff == 16'h0000)) begin
      nxt_state = PWR_ON;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= PWR_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delay_ff <= 16'h0000;
    end else if (nxt_load) begin
      delay_ff <= nxt_short ? 16'(SHORT_CYC) : 16'(FULL_CYC);
    end else if ((state_ff == PWR_WAKING) && (delay_ff != 16'h0000)) begin
      delay_ff <= delay_ff - 16'h0001;
    end
  end

  // reference stays up in standby unless disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      powered_o <= 1'b0;
      waking_o <= 1'b0;
      ref_on_o <= 1'b0;
    end else begin
      powered_o <= (nxt_state == PWR_ON);
      waking_o <= (nxt_state == PWR_WAKING);
      ref_on_o <= !ref_dis && (nxt_state != PWR_OFF);
    end
  end

  // ------------------------------------------------------------
  // Result validity and abort
  // ------------------------------------------------------------
  logic frame_open_ff;
  logic abort;

  assign abort = (mode == select_controlled_shutdown_mode) && cs_rise && frame_open_ff;

  // a new frame opens on every chip-select fall
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frame_open_ff <= 1'b0;
    end else if (cs_fall) begin
      frame_open_ff <= 1'b1;
    end else if (rise[0] || cs_rise) begin
      frame_open_ff <= 1'b0;
    end
  end

  // sample valid only when powered; set beats clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_valid_o <= 1'b0;
      conv_abort_o <= 1'b0;
    end else begin
      conv_abort_o <= abort;
      if (rise[2]) begin
        result_valid_o <= (state_ff == PWR_ON);
      end else if (abort || cs_fall) begin
        result_valid_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/adc_pwr_host.sv]
// Host end: makes the serial clock by division, sends the control
// word, collects the result and waits out the power-up delay.
// Assumes the converter end samples data-in on rising edges.
`timescale 1ns/100ps
`default_nettype none
`include "adc_pwr_params.svh"

module adc_pwr_host
  import adc_pwr_pkg::*;
#(
  parameter int HALF_CYC = `SCLK_HALF_CYC,
  parameter int FULL_CYC = `PWRUP_FULL_CYC,
  parameter int SHORT_CYC = `PWRUP_SHORT_CYC
) (
  adc_link_if.host lnk,
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] ctrl_i,
  input wire logic no_wait_i,
  output logic busy_o,
  output logic done_o,
  output logic [11:0] result_o
);

  localparam logic [4:0] FRAME_END = 5'(`FRAME_EDGES);
  localparam logic [4:0] CTRL_END = 5'(`CTRL_BITS);

  host_state_t state_ff;
  logic [15:0] timer_ff;
  logic [4:0] bit_cnt_ff;
  logic [7:0] tx_ff;
  logic [7:0] last_ctrl_ff;
  logic [15:0] rx_ff;
  logic dummy_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic din_ff;
  logic dout_s1_ff;
  logic dout_s2_ff;
  logic [15:0] wait_cyc;
  logic [1:0] last_mode;

  // ------------------------------------------------------------
  // Data-out from the pin, two stages before use
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dout_s1_ff <= 1'b0;
      dout_s2_ff <= 1'b0;
    end else begin
      dout_s1_ff <= lnk.dout;
      dout_s2_ff <= dout_s1_ff;
    end
  end

  // delay owed for the mode left behind by the last frame
  assign last_mode = last_ctrl_ff[`CTRL_PM_HI:`CTRL_PM_LO];
  always_comb begin
    wait_cyc = 16'h0000;
    if (last_mode == always_on_mode) begin
      wait_cyc = 16'h0000;
    end else if ((last_mode == auto_standby_mode) || last_ctrl_ff[`CTRL_REF_DIS]) begin
      wait_cyc = 16'(SHORT_CYC);
    end else begin
      wait_cyc = 16'(FULL_CYC);
    end
  end

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  // Clock idles high so the first edge in a frame is a falling one
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= H_IDLE;
      timer_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      tx_ff <= 8'h00;
      rx_ff <= 16'h0000;
      dummy_ff <= 1'b0;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      din_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        H_IDLE: begin
          if (start_i || dummy_ff) begin
            // dummy frame forces the always-on mode
            if (!dummy_ff && no_wait_i && (wait_cyc != 16'h0000)) begin
              dummy_ff <= 1'b1;
              tx_ff <= {ctrl_i[7:2], 2'b01};
              din_ff <= ctrl_i[7];
            end else begin
              dummy_ff <= 1'b0;
              // caller's word goes out on every frame but the dummy one
              tx_ff <= ctrl_i;
              din_ff <= ctrl_i[7];
            end
            cs_n_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
            timer_ff <= 16'(HALF_CYC);
            state_ff <= H_SELECT;
          end
        end
        H_SELECT: begin
          if (timer_ff == 16'h0000) begin
            sclk_ff <= 1'b0;
            // wait between first fall and first rise
            timer_ff <= 16'(HALF_CYC) + (no_wait_i ? 16'h0000 : wait_cyc);
            state_ff <= H_LOW;
          end else begin
            timer_ff <= timer_ff - 16'h0001;
          end
        end
        H_LOW: begin
          if (timer_ff == 16'h0000) begin
            sclk_ff <= 1'b1;
            rx_ff <= {rx_ff[14:0], dout_s2_ff};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            timer_ff <= 16'(HALF_CYC);
            state_ff <= H_HIGH;
          end else begin
            timer_ff <= timer_ff - 16'h0001;
          end
        end
        H_HIGH: begin
          if (timer_ff != 16'h0000) begin
            timer_ff <= timer_ff - 16'h0001;
          end else if (bit_cnt_ff == FRAME_END) begin
            cs_n_ff <= 1'b1;
            din_ff <= 1'b0;
            timer_ff <= 16'(`CS_HIGH_CYC);
            state_ff <= H_END;
          end else begin
            sclk_ff <= 1'b0;
            din_ff <= (bit_cnt_ff < CTRL_END) ? tx_ff[3'(7 - bit_cnt_ff)] : 1'b0;
            timer_ff <= 16'(HALF_CYC);
            state_ff <= H_LOW;
          end
        end
        H_END: begin
          if (timer_ff == 16'h0000) begin
            state_ff <= H_IDLE;
          end else begin
            timer_ff <= timer_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // Cold start leaves the converter in mode zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_ctrl_ff <= `CTRL_RESET;
    end else if ((state_ff == H_HIGH) && (timer_ff == 16'h0000) && (bit_cnt_ff == FRAME_END)) begin
      last_ctrl_ff <= tx_ff;
    end
  end

  // ------------------------------------------------------------
  // User-side status; the dummy frame's result is dropped
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= 12'h000;
    end else begin
      busy_o <= (state_ff != H_IDLE) || start_i || dummy_ff;
      done_o <= (state_ff == H_END) && (timer_ff == 16'h0000) && !dummy_ff;
      if ((state_ff == H_END) && (timer_ff == 16'h0000) && !dummy_ff) begin
        result_o <= rx_ff[11:0];
      end
    end
  end

  assign lnk.sclk = sclk_ff;
  assign lnk.cs_n = cs_n_ff;
  assign lnk.din = din_ff;

endmodule

`default_nettype wire

// [dv/adc_pwr_props.sv]
// Checker for the host-to-converter link and the converter's status.
// Assumes it sits beside the first link, fed by name from the bench.
`timescale 1ns/100ps
`default_nettype none

module adc_pwr_props #(
  parameter int FULL_CYC = 50,
  parameter int SHORT_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic [7:0] ctrl_o,
  input wire logic [1:0] power_mode_o,
  input wire logic powered_o,
  input wire logic waking_o,
  input wire logic ref_on_o
);
  logic [4:0] rise_cnt_ff;
  logic [15:0] wake_cnt_ff;

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Rises since chip-select fell, cleared by chip-select like the device
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_ff <= 5'h00;
    end else if (rise_cnt_ff != 5'h1F) begin
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
  end

  // Length of the last power-up delay, held until the next one
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_cnt_ff <= 16'h0000;
    end else if (waking_o) begin
      wake_cnt_ff <= $past(waking_o) ? wake_cnt_ff + 16'h0001 : 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  oe_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n |-> !dout_oe) else $error("data out driven while deselected");
  lead_zero_a: assert property (@(posedge sclk) disable iff (cs_n)
    rise_cnt_ff < 5'h04 |-> dout == 1'b0) else $error("leading bit not zero");
  oe_frame_a: assert property (@(posedge sclk) disable iff (cs_n)
    rise_cnt_ff < 5'h10 |-> dout_oe) else $error("data out released in frame");
  mode_one_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    powered_o && power_mode_o == 2'b01 |=> powered_o) else $error("always-on lost power");
  cs_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cs_n && power_mode_o == 2'b00) [*6] |-> !powered_o && !waking_o)
    else $error("mode zero powered while deselected");
  wake_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(powered_o) |-> $past(waking_o)) else $error("powered without delay");
  wake_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(powered_o) |-> wake_cnt_ff >= SHORT_CYC - 1 && wake_cnt_ff <= FULL_CYC + 2)
    else $error("power-up delay out of range");
  auto_down_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (power_mode_o[1] && rise_cnt_ff == 5'h10) [*6] |-> !powered_o)
    else $error("auto mode still powered after last rise");
  ref_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ctrl_o[5]) |=> !ref_on_o) else $error("reference kept on when disabled");
  ref_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (power_mode_o == 2'b11 && !ctrl_o[5]) [*2] |-> ref_on_o)
    else $error("standby dropped the reference");
endmodule

`default_nettype wire

// [dv/tb.sv]
// Bench: host end facing converter end, plus a second converter whose
// link the bench drives itself with its own serial clock.
// Assumes design files, package and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int FULL = 12;
  localparam int SHORT = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic no_wait_i = 1'b0;
  logic [7:0] ctrl_i = 8'h00;
  logic [11:0] conv_data_i = 12'h000;
  logic [11:0] result_o;
  logic [7:0] ctrl_o, ctrl2_o;
  logic [1:0] power_mode_o;
  logic busy_o, done_o, powered_o, waking_o, ref_on_o, valid_o;
  logic powered2_o, valid2_o, abort2_o;
  logic saw_wake = 1'b0;
  logic saw_abort = 1'b0;
  logic [15:0] got = 16'h0000;
  int wake_len = 0;
  int mismatches = 0;
  int samples_checked = 0;

  always #50 clk_i = ~clk_i;

  adc_link_if lnk();
  adc_link_if lnk2();

  adc_pwr_host #(.FULL_CYC(FULL), .SHORT_CYC(SHORT)) adc_pwr_host_i (.lnk(lnk.host),
    .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .ctrl_i(ctrl_i),
    .no_wait_i(no_wait_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o));
  adc_pwr_device #(.FULL_CYC(FULL), .SHORT_CYC(SHORT)) adc_pwr_device_i (.lnk(lnk.device),
    .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_data_i(conv_data_i), .ctrl_o(ctrl_o),
    .power_mode_o(power_mode_o), .powered_o(powered_o), .waking_o(waking_o),
    .ref_on_o(ref_on_o), .result_valid_o(valid_o), .conv_abort_o());
  adc_pwr_device #(.FULL_CYC(FULL), .SHORT_CYC(SHORT)) adc_pwr_device_i2 (.lnk(lnk2.device),
    .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_data_i(conv_data_i), .ctrl_o(ctrl2_o),
    .power_mode_o(), .powered_o(powered2_o), .waking_o(), .ref_on_o(),
    .result_valid_o(valid2_o), .conv_abort_o(abort2_o));
  adc_pwr_props #(.FULL_CYC(FULL), .SHORT_CYC(SHORT)) adc_pwr_props_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .dout(lnk.dout),
    .dout_oe(lnk.dout_oe), .ctrl_o(ctrl_o), .power_mode_o(power_mode_o),
    .powered_o(powered_o), .waking_o(waking_o), .ref_on_o(ref_on_o));

  // Status seen during a frame; host_frame clears the wake record before each frame
  always @(posedge clk_i) begin
    if (waking_o) begin
      saw_wake <= 1'b1;
      wake_len <= wake_len + 1;
    end
    if (abort2_o) begin
      saw_abort <= 1'b1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One frame through the host; result checked against the core value
  task automatic host_frame(input logic [7:0] w, input logic nw, input logic [11:0] d);
    int n;
    @(posedge clk_i) #1;
    conv_data_i = d;
    ctrl_i = w;
    no_wait_i = nw;
    saw_wake = 1'b0;
    wake_len = 0;
    start_i = 1'b1;
    @(posedge clk_i) #1;
    start_i = 1'b0;
    check(busy_o, 1'b1, "busy after start");
    n = 0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i) #1;
      n++;
    end
    check(done_o, 1'b1, "frame never completed");
    check(result_o, d, "result");
    @(posedge clk_i) #1;
    check(busy_o, 1'b0, "idle after done");
  endtask

  // Bench-made link frame: slow clock unrelated to the system clock,
  // first transition falling, data in set on falls, data out read before rises
  task automatic bang(input logic [7:0] w, input int rises);
    #37 lnk2.cs_n = 1'b0;
    #125;
    for (int i = 0; i < rises; i++) begin
      lnk2.sclk = 1'b0;
      lnk2.din = (i < 8) ? w[7 - i] : 1'b0;
      #62.5;
      got = {got[14:0], lnk2.dout};
      lnk2.sclk = 1'b1;
      #62.5;
    end
    // Hold the select past three system clocks so the end event crosses
    #300 lnk2.cs_n = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  initial begin
    lnk2.sclk = 1'b1;
    lnk2.din = 1'b0;
    // A step in, so the link flops are waiting when chip-select rises
    #1 lnk2.cs_n = 1'b1;
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    @(posedge clk_i) #1;
    check(ctrl_o, 8'h00, "cold control word");
    check(powered_o, 1'b0, "cold power");
    $display("test cold start done");
    host_frame(8'h00, 1'b0, 12'hABC);
    check(valid_o, 1'b1, "mode zero valid");
    check(saw_wake, 1'b1, "mode zero wake");
    check(powered_o, 1'b0, "mode zero off");
    $display("test select controlled done");
    host_frame(8'h01, 1'b0, 12'h5A3);
    check(ctrl_o, 8'h01, "control loaded");
    host_frame(8'h01, 1'b0, 12'h3C5);
    check(saw_wake, 1'b0, "always on no delay");
    check(valid_o, 1'b1, "always on valid");
    check(powered_o, 1'b1, "always on powered");
    $display("test always on done");
    host_frame(8'h02, 1'b0, 12'h0F1);
    check(powered_o, 1'b0, "auto shutdown");
    check(ref_on_o, 1'b0, "shutdown reference");
    host_frame(8'h02, 1'b0, 12'h7E8);
    check(saw_wake, 1'b1, "auto wake");
    check(wake_len >= FULL, 1'b1, "full delay");
    check(valid_o, 1'b1, "auto valid");
    check(ctrl_o, 8'h02, "control kept");
    $display("test auto shutdown done");
    host_frame(8'h03, 1'b0, 12'h246);
    check(powered_o, 1'b0, "standby off");
    check(ref_on_o, 1'b1, "standby reference");
    host_frame(8'h03, 1'b0, 12'h9BD);
    check(wake_len <= SHORT + 2, 1'b1, "standby short delay");
    check(valid_o, 1'b1, "standby same frame");
    $display("test auto standby done");
    host_frame(8'h22, 1'b0, 12'h135);
    host_frame(8'h22, 1'b0, 12'hFED);
    check(wake_len <= SHORT + 2, 1'b1, "external ref delay");
    check(ref_on_o, 1'b0, "reference disabled");
    check(valid_o, 1'b1, "external ref valid");
    $display("test external reference done");
    host_frame(8'h00, 1'b1, 12'h864);
    check(valid_o, 1'b1, "dummy frame path valid");
    check(ctrl_o, 8'h00, "mode restored");
    $display("test no wait done");
    conv_data_i = 12'hC39;
    bang(8'hA5, 16);
    check(ctrl2_o, 8'hA5, "bit order");
    check(got, 16'h0C39, "wire word");
    check(valid2_o, 1'b0, "early sample invalid");
    check(powered2_o, 1'b1, "mode one stays on");
    bang(8'h00, 16);
    check(valid2_o, 1'b1, "powered sample valid");
    check(got, 16'h0C39, "read only word");
    check(powered2_o, 1'b0, "deselect off");
    check(saw_abort, 1'b0, "full frame not aborted");
    bang(8'h00, 6);
    check(saw_abort, 1'b1, "abort seen");
    check(powered2_o, 1'b0, "abort off");
    check(valid2_o, 1'b0, "abort invalid");
    $display("test direct link done");
    complete_run();
  end

  initial begin
    #3000000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
